// ### inc/port_mode_defs.vh
// Constants for the port mode control block: register map, fields, reset values
`ifndef PORT_MODE_DEFS_VH
`define PORT_MODE_DEFS_VH

// ----------------------------------------------------------------
// Register byte addresses (one aligned 32-bit word each)
// ----------------------------------------------------------------
`define ADDR_CTRL_A 12'h000
`define ADDR_CTRL_B 12'h004
`define ADDR_DIR_A 12'h008
`define ADDR_DIR_B 12'h00C
`define ADDR_DIR_C 12'h010
`define ADDR_DIR_D 12'h014
`define ADDR_DRV_A 12'h018
`define ADDR_DRV_B 12'h01C
`define ADDR_DRV_C 12'h020
`define ADDR_DRV_D 12'h024
`define ADDR_DOUT_A 12'h028
`define ADDR_DOUT_B 12'h02C
`define ADDR_DOUT_C 12'h030
`define ADDR_DOUT_D 12'h034
`define ADDR_DIN_A 12'h038
`define ADDR_DIN_B 12'h03C
`define ADDR_DIN_C 12'h040
`define ADDR_DIN_D 12'h044
`define ADDR_MEM_MODE 12'h048
`define ADDR_BUS_CFG 12'h04C
`define ADDR_HIADDR 12'h050

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define PIO_BIT 7
`define BUSCFG_NONMUX_BIT 0
`define BUSCFG_DATAPORT_BIT 1
`define BUSCFG_JTAGCFG_BIT 2
`define PORTD_MASK 3'h7
`define CFG_RESET 8'h00
`define MEM_MODE_RESET 8'h00
`define BUSCFG_RESET 8'h00

`endif

// ### rtl/port_mode_control.v
// Mode control for four I/O ports with an APB register slave
//
// Summary of operation
// - Pin drives latched address when its mode bit is set and its oe term or direction bit is set.
// - On an 8-bit non-multiplexed bus, low address lines appear only on port B.
// - Port A can serve as data bus for a non-multiplexed host.
// - Data bus mode on port A disables all its general I/O functions.
// - High address bits on ports A to D latch on the address strobe.
// - Port inputs used in memory select decode are treated as address inputs.
// - Writing one to bit 7 of memory mode register enables peripheral I/O.
// - In peripheral I/O mode port A is a bidirectional host data buffer.
// - Peripheral buffer stays high impedance unless a peripheral select is active.
// - Port C carries programming pins shared with its other functions.
// - Programming pins enabled by select term, stored config, or enable input.
// - Each pin driver enable is direction bit ORed with its oe term, except port A in data bus, peripheral or non-multiplexed mode.
// - Configuration registers are read and written with ordinary bus cycles.
// - Bit n of each port mode, direction and data out register controls pin n only; drive registers control nothing.
// - All configuration registers reset to zero.
// - Mode bit zero selects host I/O, one selects address out; ports A, B only.
// - Direction one is output, zero input; port D has three direction bits.
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "port_mode_defs.vh"

module port_mode_control #(
  parameter AW = 12
) (
  input wire clk_sys_i,
  input wire rst_n_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [AW-1:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // Host bus side
  input wire address_latch_strobe_i,
  input wire [15:0] host_addr_i,
  input wire [7:0] host_data_i,
  input wire host_data_write_i,
  output reg [7:0] host_data_o,
  // Product terms from the logic arrays
  input wire [7:0] oe_term_a_i,
  input wire [7:0] oe_term_b_i,
  input wire [7:0] oe_term_c_i,
  input wire [2:0] oe_term_d_i,
  input wire [7:0] decode_use_a_i,
  input wire [7:0] decode_use_b_i,
  input wire [7:0] decode_use_c_i,
  input wire [2:0] decode_use_d_i,
  input wire periph_select_0_i,
  input wire periph_select_1_i,
  input wire boundary_port_select_term_i,
  input wire jtag_enable_i,
  // Pins
  input wire [7:0] port_a_in_i,
  input wire [7:0] port_b_in_i,
  input wire [7:0] port_c_in_i,
  input wire [2:0] port_d_in_i,
  output reg [7:0] port_a_out_o,
  output reg [7:0] port_a_oe_o,
  output reg [7:0] port_b_out_o,
  output reg [7:0] port_b_oe_o,
  output reg [7:0] port_c_out_o,
  output reg [7:0] port_c_oe_o,
  output reg [2:0] port_d_out_o,
  output reg [2:0] port_d_oe_o,
  output reg jtag_pins_enable_o,
  output reg [31:0] hi_addr_latched_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [7:0] ctrl_a_reg;
  reg [7:0] ctrl_b_reg;
  reg [7:0] dir_a_reg;
  reg [7:0] dir_b_reg;
  reg [7:0] dir_c_reg;
  reg [2:0] dir_d_reg;
  reg [7:0] drv_a_reg;
  reg [7:0] drv_b_reg;
  reg [7:0] drv_c_reg;
  reg [2:0] drv_d_reg;
  reg [7:0] dout_a_reg;
  reg [7:0] dout_b_reg;
  reg [7:0] dout_c_reg;
  reg [2:0] dout_d_reg;
  reg [7:0] memory_mode_reg;
  reg [7:0] bus_cfg_reg;
  reg [7:0] lat_addr_reg;
  reg [7:0] lat_a_reg;
  reg [7:0] lat_b_reg;
  reg [7:0] lat_c_reg;
  reg [2:0] lat_d_reg;

  wire wr_en = psel_i & penable_i & pwrite_i;
  wire rd_setup = psel_i & ~penable_i & ~pwrite_i;
  wire periph_io_enable = memory_mode_reg[`PIO_BIT];
  wire nonmux_bus = bus_cfg_reg[`BUSCFG_NONMUX_BIT];
  wire data_port_mode = bus_cfg_reg[`BUSCFG_DATAPORT_BIT];
  wire periph_sel = periph_select_0_i | periph_select_1_i;

  // Pin output value: latched address where ctrl set, else data out
  function [7:0] pin_out;
    input [7:0] ctrl;
    input [7:0] addr;
    input [7:0] dout;
    begin
      pin_out = (ctrl & addr) | (~ctrl & dout);
    end
  endfunction

  // Low nibble carries address 3..0, high nibble 7..4; port A gets zero on a non-multiplexed bus
  function [7:0] addr_for_port;
    input [7:0] la;
    input is_port_b;
    begin
      if (nonmux_bus && !is_port_b) begin
        addr_for_port = `CFG_RESET;
      end else begin
        addr_for_port = {la[7:4], la[3:0]};
      end
    end
  endfunction

  // Pins outside the decode mask keep their old latched value
  function [7:0] latch_merge;
    input [7:0] old;
    input [7:0] pins;
    input [7:0] use_mask;
    begin
      latch_merge = (old & ~use_mask) | (pins & use_mask);
    end
  endfunction

  // ----------------------------------------------------------------
  // APB register writes
  // ----------------------------------------------------------------
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_a_reg <= `CFG_RESET;
      ctrl_b_reg <= `CFG_RESET;
      dir_a_reg <= `CFG_RESET;
      dir_b_reg <= `CFG_RESET;
      dir_c_reg <= `CFG_RESET;
      dir_d_reg <= 3'h0;
      drv_a_reg <= `CFG_RESET;
      drv_b_reg <= `CFG_RESET;
      drv_c_reg <= `CFG_RESET;
      drv_d_reg <= 3'h0;
      dout_a_reg <= `CFG_RESET;
      dout_b_reg <= `CFG_RESET;
      dout_c_reg <= `CFG_RESET;
      dout_d_reg <= 3'h0;
      memory_mode_reg <= `MEM_MODE_RESET;
      bus_cfg_reg <= `BUSCFG_RESET;
    end else if (wr_en) begin
      case (paddr_i)
        `ADDR_CTRL_A: ctrl_a_reg <= pwdata_i[7:0];
        `ADDR_CTRL_B: ctrl_b_reg <= pwdata_i[7:0];
        `ADDR_DIR_A: dir_a_reg <= pwdata_i[7:0];
        `ADDR_DIR_B: dir_b_reg <= pwdata_i[7:0];
        `ADDR_DIR_C: dir_c_reg <= pwdata_i[7:0];
        `ADDR_DIR_D: dir_d_reg <= pwdata_i[2:0];
        `ADDR_DRV_A: drv_a_reg <= pwdata_i[7:0];
        `ADDR_DRV_B: drv_b_reg <= pwdata_i[7:0];
        `ADDR_DRV_C: drv_c_reg <= pwdata_i[7:0];
        `ADDR_DRV_D: drv_d_reg <= pwdata_i[2:0];
        `ADDR_DOUT_A: dout_a_reg <= pwdata_i[7:0];
        `ADDR_DOUT_B: dout_b_reg <= pwdata_i[7:0];
        `ADDR_DOUT_C: dout_c_reg <= pwdata_i[7:0];
        `ADDR_DOUT_D: dout_d_reg <= pwdata_i[2:0];
        `ADDR_MEM_MODE: memory_mode_reg <= pwdata_i[7:0];
        `ADDR_BUS_CFG: bus_cfg_reg <= pwdata_i[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // APB read and answer: one wait-free access phase
  // ----------------------------------------------------------------
  reg [31:0] rd_data;
  reg rd_hit;
  always @* begin
    rd_hit = 1'b1;
    rd_data = 32'h0000_0000;
    case (paddr_i)
      `ADDR_CTRL_A: rd_data[7:0] = ctrl_a_reg;
      `ADDR_CTRL_B: rd_data[7:0] = ctrl_b_reg;
      `ADDR_DIR_A: rd_data[7:0] = dir_a_reg;
      `ADDR_DIR_B: rd_data[7:0] = dir_b_reg;
      `ADDR_DIR_C: rd_data[7:0] = dir_c_reg;
      `ADDR_DIR_D: rd_data[2:0] = dir_d_reg;
      `ADDR_DRV_A: rd_data[7:0] = drv_a_reg;
      `ADDR_DRV_B: rd_data[7:0] = drv_b_reg;
      `ADDR_DRV_C: rd_data[7:0] = drv_c_reg;
      `ADDR_DRV_D: rd_data[2:0] = drv_d_reg;
      `ADDR_DOUT_A: rd_data[7:0] = dout_a_reg;
      `ADDR_DOUT_B: rd_data[7:0] = dout_b_reg;
      `ADDR_DOUT_C: rd_data[7:0] = dout_c_reg;
      `ADDR_DOUT_D: rd_data[2:0] = dout_d_reg;
      `ADDR_DIN_A: rd_data[7:0] = port_a_in_i;
      `ADDR_DIN_B: rd_data[7:0] = port_b_in_i;
      `ADDR_DIN_C: rd_data[7:0] = port_c_in_i;
      `ADDR_DIN_D: rd_data[2:0] = port_d_in_i;
      `ADDR_MEM_MODE: rd_data[7:0] = memory_mode_reg;
      `ADDR_BUS_CFG: rd_data[7:0] = bus_cfg_reg;
      `ADDR_HIADDR: rd_data = {5'h00, lat_d_reg, lat_c_reg, lat_b_reg, lat_a_reg};
      default: rd_hit = 1'b0;
    endcase
  end

  // Ready rises in the first access cycle and drops with it
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~rd_hit;
      if (rd_setup) begin
        prdata_o <= rd_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Address strobe latches
  // ----------------------------------------------------------------
  // Port D is widened to a byte so that it shares the merge function
  wire [7:0] lat_d_merged = latch_merge({5'h00, lat_d_reg}, {5'h00, port_d_in_i},
    {5'h00, decode_use_d_i});

  // The strobe is sampled as a level: latches stay transparent while high
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lat_addr_reg <= `CFG_RESET;
      lat_a_reg <= `CFG_RESET;
      lat_b_reg <= `CFG_RESET;
      lat_c_reg <= `CFG_RESET;
      lat_d_reg <= 3'h0;
    end else if (address_latch_strobe_i) begin
      lat_addr_reg <= host_addr_i[7:0];
      // Only pins that feed memory decode count as address inputs
      lat_a_reg <= latch_merge(lat_a_reg, port_a_in_i, decode_use_a_i);
      lat_b_reg <= latch_merge(lat_b_reg, port_b_in_i, decode_use_b_i);
      lat_c_reg <= latch_merge(lat_c_reg, port_c_in_i, decode_use_c_i);
      lat_d_reg <= lat_d_merged[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Address out needs ctrl plus oe term or dir; ctrl alone leaves the pin undriven
  wire [7:0] a_addr = addr_for_port(lat_addr_reg, 1'b0);
  wire [7:0] b_addr = addr_for_port(lat_addr_reg, 1'b1);
  wire [7:0] a_gpio_oe = dir_a_reg | oe_term_a_i;
  wire [7:0] b_gpio_oe = dir_b_reg | oe_term_b_i;
  wire [7:0] a_mask = nonmux_bus ? ~ctrl_a_reg : 8'hFF;

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_a_out_o <= `CFG_RESET;
      port_a_oe_o <= `CFG_RESET;
      port_b_out_o <= `CFG_RESET;
      port_b_oe_o <= `CFG_RESET;
      port_c_out_o <= `CFG_RESET;
      port_c_oe_o <= `CFG_RESET;
      port_d_out_o <= 3'h0;
      port_d_oe_o <= 3'h0;
      host_data_o <= `CFG_RESET;
      jtag_pins_enable_o <= 1'b0;
      hi_addr_latched_o <= 32'h0000_0000;
    end else begin
      if (data_port_mode) begin
        // Port A joins the host data bus; general I/O is off
        port_a_out_o <= host_data_i;
        port_a_oe_o <= {8{host_data_write_i}};
        host_data_o <= port_a_in_i;
      end else if (periph_io_enable) begin
        // Buffer floats unless a peripheral select is active
        port_a_out_o <= host_data_i;
        port_a_oe_o <= {8{periph_sel & host_data_write_i}};
        host_data_o <= periph_sel ? port_a_in_i : `CFG_RESET;
      end else begin
        port_a_out_o <= pin_out(ctrl_a_reg, a_addr, dout_a_reg);
        port_a_oe_o <= a_gpio_oe & a_mask;
        host_data_o <= `CFG_RESET;
      end
      port_b_out_o <= pin_out(ctrl_b_reg, b_addr, dout_b_reg);
      port_b_oe_o <= b_gpio_oe;
      port_c_out_o <= dout_c_reg;
      port_c_oe_o <= dir_c_reg | oe_term_c_i;
      port_d_out_o <= dout_d_reg;
      port_d_oe_o <= (dir_d_reg | oe_term_d_i) & `PORTD_MASK;
      jtag_pins_enable_o <= boundary_port_select_term_i | bus_cfg_reg[`BUSCFG_JTAGCFG_BIT]
        | jtag_enable_i;
      hi_addr_latched_o <= {5'h00, lat_d_reg, lat_c_reg, lat_b_reg, lat_a_reg};
    end
  end

endmodule // port_mode_control

// ### tb/port_mode_monitor.sv
// Assertion checker for the port mode control block
`timescale 1ns/1ps
`include "port_mode_defs.vh"
module port_mode_monitor (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [7:0] decode_use_a_i,
  input wire [7:0] decode_use_b_i,
  input wire [7:0] decode_use_c_i,
  input wire [2:0] decode_use_d_i,
  input wire pready_o,
  input wire pslverr_o,
  input wire [31:0] prdata_o,
  input wire address_latch_strobe_i,
  input wire [7:0] port_a_in_i,
  input wire [7:0] port_b_in_i,
  input wire [7:0] port_c_in_i,
  input wire [2:0] port_d_in_i,
  input wire [7:0] oe_term_b_i,
  input wire [7:0] oe_term_c_i,
  input wire [2:0] oe_term_d_i,
  input wire [7:0] port_b_oe_o,
  input wire [7:0] port_c_oe_o,
  input wire [2:0] port_d_oe_o,
  input wire boundary_port_select_term_i,
  input wire jtag_enable_i,
  input wire jtag_pins_enable_o,
  input wire [31:0] hi_addr_latched_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  wire [26:0] use_all = {decode_use_d_i, decode_use_c_i, decode_use_b_i, decode_use_a_i};
  wire [26:0] pin_all = {port_d_in_i, port_c_in_i, port_b_in_i, port_a_in_i};
  wire [26:0] hi_low = hi_addr_latched_o[26:0];
  chk_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  chk_ready_one_cycle: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  chk_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  chk_upper_bits_zero: assert property (psel_i && !penable_i && !pwrite_i
    && paddr_i != `ADDR_HIADDR |=> prdata_o[31:8] == 24'h0) else $error("upper read bits set");
  chk_latch_on_strobe: assert property (address_latch_strobe_i |-> ##2 hi_low ==
    (($past(hi_low) & ~$past(use_all, 2)) | ($past(pin_all, 2) & $past(use_all, 2))))
    else $error("high address not latched");
  chk_latch_holds: assert property (!address_latch_strobe_i ##1 !address_latch_strobe_i
    |=> $stable(hi_addr_latched_o)) else $error("latched address moved");
  chk_oe_term_b: assert property ((oe_term_b_i != 8'h0)
    |=> (port_b_oe_o & $past(oe_term_b_i)) == $past(oe_term_b_i)) else $error("port b oe");
  chk_oe_term_cd: assert property (({oe_term_c_i, oe_term_d_i} != 11'h0)
    |=> ({port_c_oe_o, port_d_oe_o} & $past({oe_term_c_i, oe_term_d_i}))
    == $past({oe_term_c_i, oe_term_d_i})) else $error("port c or d oe");
  chk_jtag_sources: assert property (jtag_enable_i || boundary_port_select_term_i
    |=> jtag_pins_enable_o) else $error("jtag pins not enabled");
  cover property (pslverr_o);
  cover property (address_latch_strobe_i ##1 !address_latch_strobe_i);
  cover property (jtag_enable_i ##1 jtag_pins_enable_o);
endmodule // port_mode_monitor
bind port_mode_control port_mode_monitor u_mon (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .decode_use_a_i(decode_use_a_i), .decode_use_b_i(decode_use_b_i),
  .decode_use_c_i(decode_use_c_i), .decode_use_d_i(decode_use_d_i),
  .pready_o(pready_o), .pslverr_o(pslverr_o),
  .prdata_o(prdata_o), .address_latch_strobe_i(address_latch_strobe_i),
  .port_a_in_i(port_a_in_i), .port_b_in_i(port_b_in_i), .port_c_in_i(port_c_in_i),
  .port_d_in_i(port_d_in_i), .oe_term_b_i(oe_term_b_i), .oe_term_c_i(oe_term_c_i),
  .oe_term_d_i(oe_term_d_i), .port_b_oe_o(port_b_oe_o), .port_c_oe_o(port_c_oe_o),
  .port_d_oe_o(port_d_oe_o), .boundary_port_select_term_i(boundary_port_select_term_i),
  .jtag_enable_i(jtag_enable_i), .jtag_pins_enable_o(jtag_pins_enable_o),
  .hi_addr_latched_o(hi_addr_latched_o));

// ### tb/ext_periph.sv
// Behavioural model of the external peripheral on port A
`timescale 1ns/1ps
module ext_periph (
  input wire [7:0] oe_i,
  input wire [7:0] out_i,
  input wire [7:0] val_i,
  output logic [7:0] pin_o
);
  // Not a boot memory, so address-out pins may reach it safely
  // Device wins where it drives, the peripheral drives the rest
  assign pin_o = (oe_i & out_i) | (~oe_i & val_i);
endmodule // ext_periph

// ### tb/test_port_mode_control.sv
// Testbench for the port mode control block
`timescale 1ns/1ps
`include "port_mode_defs.vh"
module test_port_mode_control;
  logic clk_sys_i = 1'h0, rst_n_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
  logic strobe = 1'h0, hd_wr = 1'h0, ps0 = 1'h0, ps1 = 1'h0, bsel = 1'h0, jen = 1'h0;
  logic pready_o, pslverr_o, jpe, e;
  logic [11:0] paddr_i = 12'h000;
  logic [15:0] haddr = 16'h0000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, hi_addr, q;
  logic [7:0] hd_in = 8'h00, oe_a = 8'h00, oe_b = 8'h00, oe_c = 8'h00, ext_val = 8'h00;
  logic [7:0] pb_in = 8'h00, pc_in = 8'h00, hd_out, pa_in, pa_out, pa_oe, pb_out, pb_oe;
  logic [7:0] pc_out, pc_oe;
  logic [2:0] oe_d = 3'h0, pd_in = 3'h0, pd_out, pd_oe;
  logic [7:0] du_a = 8'hFF, du_b = 8'hFF, du_c = 8'hFF;
  logic [2:0] du_d = 3'h7;
  int err_total = 0;
  int n_checks = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  port_mode_control dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .address_latch_strobe_i(strobe), .host_addr_i(haddr), .host_data_i(hd_in),
    .host_data_write_i(hd_wr), .host_data_o(hd_out), .oe_term_a_i(oe_a), .oe_term_b_i(oe_b),
    .oe_term_c_i(oe_c), .oe_term_d_i(oe_d), .decode_use_a_i(du_a), .decode_use_b_i(du_b),
    .decode_use_c_i(du_c), .decode_use_d_i(du_d), .periph_select_0_i(ps0),
    .periph_select_1_i(ps1), .boundary_port_select_term_i(bsel), .jtag_enable_i(jen),
    .port_a_in_i(pa_in), .port_b_in_i(pb_in), .port_c_in_i(pc_in), .port_d_in_i(pd_in),
    .port_a_out_o(pa_out), .port_a_oe_o(pa_oe), .port_b_out_o(pb_out), .port_b_oe_o(pb_oe),
    .port_c_out_o(pc_out), .port_c_oe_o(pc_oe), .port_d_out_o(pd_out), .port_d_oe_o(pd_oe),
    .jtag_pins_enable_o(jpe), .hi_addr_latched_o(hi_addr));
  ext_periph u_ext (.oe_i(pa_oe), .out_i(pa_out), .val_i(ext_val), .pin_o(pa_in));
  // ----------------------------------------------------------------
  // Bus tasks and checks
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel_i <= 1'h1;
    penable_i <= 1'h0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'h1;
    // Only the watchdog ends a wait for ready
    do begin
      @(posedge clk_sys_i);
    end while (pready_o !== 1'h1);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ex, input string nm);
    apb(1'h0, a, 32'h0);
    chk(nm, ex, q);
  endtask
  // Outputs lag their cause by up to two registers
  task automatic settle();
    repeat (4) @(posedge clk_sys_i);
  endtask
  task automatic conclude();
    if (err_total == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'h1;
    rd(`ADDR_CTRL_A, 32'h0, "ctrl_a reset");
    rd(`ADDR_DRV_C, 32'h0, "drv_c reset");
    apb(1'h0, 12'h0FC, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, e});
    apb(1'h1, `ADDR_DIR_D, 32'hFF);
    rd(`ADDR_DIR_D, 32'h07, "dir_d");
    apb(1'h1, `ADDR_CTRL_A, 32'hA5);
    rd(`ADDR_CTRL_A, 32'hA5, "ctrl_a");
    apb(1'h1, `ADDR_DIR_B, 32'h0F);
    apb(1'h1, `ADDR_DOUT_B, 32'hC3);
    apb(1'h1, `ADDR_DOUT_C, 32'h5A);
    apb(1'h1, `ADDR_DOUT_D, 32'h6);
    ext_val <= 8'h11;
    pb_in <= 8'h22;
    pc_in <= 8'h33;
    pd_in <= 3'h5;
    oe_b <= 8'h30;
    oe_c <= 8'h81;
    oe_d <= 3'h2;
    settle();
    chk("pb_oe", 32'h3F, pb_oe);
    chk("pb_out io", 32'hC3, pb_out);
    chk("pa_oe ctrl only", 32'h0, pa_oe);
    chk("pc_oe", 32'h81, pc_oe);
    chk("pd_oe", 32'h7, pd_oe);
    chk("pc_out", 32'h5A, pc_out);
    chk("pd_out", 32'h6, pd_out);
    rd(`ADDR_DIN_C, 32'h33, "din_c");
    apb(1'h1, `ADDR_CTRL_B, 32'hFF);
    haddr <= 16'h125A;
    strobe <= 1'h1;
    settle();
    strobe <= 1'h0;
    haddr <= 16'hFFFF;
    pc_in <= 8'h00;
    settle();
    chk("pb_out addr", 32'h5A, pb_out);
    chk("pb_oe addr", 32'h3F, pb_oe);
    chk("hi addr", 32'h05332211, hi_addr);
    rd(`ADDR_HIADDR, 32'h05332211, "hiaddr reg");
    du_b <= 8'h0F;
    pb_in <= 8'hEE;
    haddr <= 16'h125A;
    strobe <= 1'h1;
    settle();
    strobe <= 1'h0;
    settle();
    chk("hi addr masked", 32'h05002E11, hi_addr);
    apb(1'h1, `ADDR_CTRL_B, 32'hF0);
    settle();
    chk("pb_out mixed", 32'h53, pb_out);
    apb(1'h1, `ADDR_BUS_CFG, 32'h1);
    apb(1'h1, `ADDR_DIR_A, 32'hFF);
    settle();
    chk("pa_oe nonmux", 32'h5A, pa_oe);
    apb(1'h1, `ADDR_BUS_CFG, 32'h0);
    apb(1'h1, `ADDR_MEM_MODE, 32'h80);
    settle();
    chk("periph idle", 32'h0, pa_oe);
    ps0 <= 1'h1;
    hd_wr <= 1'h1;
    hd_in <= 8'h3C;
    settle();
    chk("periph out", 32'h3C, pa_out);
    chk("periph oe", 32'hFF, pa_oe);
    ps0 <= 1'h0;
    ps1 <= 1'h1;
    hd_wr <= 1'h0;
    ext_val <= 8'h96;
    settle();
    chk("periph in", 32'h96, hd_out);
    chk("periph read oe", 32'h0, pa_oe);
    apb(1'h1, `ADDR_MEM_MODE, 32'h0);
    apb(1'h1, `ADDR_BUS_CFG, 32'h2);
    ps1 <= 1'h0;
    oe_a <= 8'hFF;
    ext_val <= 8'h69;
    settle();
    chk("data port in", 32'h69, hd_out);
    chk("data port oe", 32'h0, pa_oe);
    for (int i = 0; i < 3; i++) begin
      bsel <= (i == 0);
      jen <= (i == 2);
      apb(1'h1, `ADDR_BUS_CFG, (i == 1) ? 32'h4 : 32'h0);
      settle();
      chk("jtag source", 32'h1, {31'h0, jpe});
    end
    jen <= 1'h0;
    settle();
    chk("jtag off", 32'h0, {31'h0, jpe});
    rst_n_i <= 1'h0;
    settle();
    rst_n_i <= 1'h1;
    rd(`ADDR_CTRL_B, 32'h0, "ctrl_b reset");
    conclude();
  end
endmodule // test_port_mode_control
